// File: core/sim_monitor.sv
/*
 System integrity monitor: APB slave with one 8-bit control/status
 register, reset-cause flags, supply warning and clock guard interrupts,
 wait and halt handling.
 Assumes analog comparators and reset sequencing sit outside; reset
 cause pulses arrive together with or during srst_in.
*/
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// R1: Filter oscillator glitches only with PLL on
// R2: Switch to safe oscillator on clock loss
// R3: Return to main oscillator on recovery
// R4: Safe-clock flag set while safe clock drives
// R5: Interrupt needs enable and cleared CPU mask
// R6: Wait unaffected; interrupts wake wait, not halt
// R7: Halt freezes status and disables clock guard
// R8: Halt exit resumes guard; reset restarts counter
// R9: Register bit layout, reset value zero
// R10: Supply warning toggle interrupts, cleared on entry
// R11: Supply warning flag is hardware read-only
// R12: Brownout flag set on low-voltage reset, write-zero clears
// R13: Software writes zero to bit 3
// R14: Clock guard enable inert when guard disabled
// R15: Safe flag cleared by read after recovery
// R16: Watchdog flag set by watchdog, cleared otherwise
// R17: Reset cause encoding in two flags
// R18: Brownout flag survives later other resets
// R19: Software ignores watchdog flag without detector
// R20: Supply warning works only with detector enabled
// R21: Byte register, live reads, masked writes
module sim_monitor
(
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic srst_in,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Configuration options
   input wire logic lvd_option_in,
   input wire logic guard_option_in,
   input wire logic pll_on_in,
   // Reset causes, one-cycle pulses
   input wire logic lvd_reset_in,
   input wire logic wdg_reset_in,
   // Analog and oscillator
   input wire logic supply_low_in,
   input wire logic osc_sample_in,
   // CPU side
   input wire logic cpu_int_mask_in,
   input wire logic halt_in,
   input wire logic wait_in,
   input wire logic sw_irq_ack_in,
   // Outputs
   output logic osc_filtered_out,
   output logic safe_select_out,
   output logic sw_irq_out,
   output logic cg_irq_out,
   output logic wake_out
);
   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   logic sw_ie;
   logic cg_ie;
   logic bor_flag;
   logic wdg_flag;
   logic safe_flag;
   logic sw_pending;
   logic sw_level;
   logic sw_toggle;
   logic guard_safe;
   logic guard_filt;
   logic guard_en;
   logic hit;
   logic wr_acc;
   logic rd_acc;
   logic [7:0] status;

   function automatic logic reg_hit(input logic [11:0] addr);
      reg_hit = (addr == sim_pkg::SIM_ADDR_CTRL_STATUS);
   endfunction : reg_hit

   // ------------------------------------------------------------------
   // Submodules
   // ------------------------------------------------------------------
   assign guard_en = guard_option_in;

   // Supply comparator crossing into core clock
   sim_edge_sync u_supply_sync
   (
      .core_clk_in(core_clk_in),
      .srst_in(srst_in),
      .level_in(supply_low_in & lvd_option_in), // [R20]
      .level_out(sw_level),
      .toggle_out(sw_toggle)
   );

   // Oscillator guard
   sim_clock_guard u_guard
   (
      .core_clk_in(core_clk_in),
      .srst_in(srst_in),
      .enable_in(guard_en),
      .freeze_in(halt_in), // [R7]
      .pll_on_in(pll_on_in),
      .osc_sample_in(osc_sample_in),
      .osc_filtered_out(guard_filt),
      .safe_select_out(guard_safe)
   );

   // ------------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------------
   assign hit = reg_hit(paddr);
   assign wr_acc = psel & penable & pready & pwrite & hit;
   assign rd_acc = psel & penable & pready & ~pwrite & hit;

   // Live register view, bit 3 and 7 read zero
   always_comb
   begin
      status = sim_pkg::SIM_CTRL_STATUS_RESET; // [R9]
      status[sim_pkg::SIM_BIT_SW_IE] = sw_ie;
      status[sim_pkg::SIM_BIT_SW_FLAG] = sw_level & lvd_option_in; // [R11] [R20]
      status[sim_pkg::SIM_BIT_BOR] = bor_flag;
      status[sim_pkg::SIM_BIT_CG_IE] = cg_ie;
      status[sim_pkg::SIM_BIT_SAFE] = safe_flag & guard_en; // [R15]
      status[sim_pkg::SIM_BIT_WDG] = wdg_flag;
   end

   // APB answer: one wait state, error on unmapped address
   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~hit;
         if (psel & penable & ~pready & ~pwrite & hit)
            prdata <= {24'h00_0000, status}; // [R21]
         else
            prdata <= 32'h0000_0000;
      end
   end

   // ------------------------------------------------------------------
   // Control bits
   // ------------------------------------------------------------------
   // Enables are software read/write; bit 3 never stored
   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
      begin
         sw_ie <= 1'b0;
         cg_ie <= 1'b0;
      end
      else if (wr_acc)
      begin
         sw_ie <= pwdata[sim_pkg::SIM_BIT_SW_IE]; // [R10] [R21]
         cg_ie <= pwdata[sim_pkg::SIM_BIT_CG_IE]; // [R14] [R13]
      end
   end

   // ------------------------------------------------------------------
   // Reset-cause flags, kept across srst_in
   // ------------------------------------------------------------------
   // Brownout flag: set by low-voltage reset, write zero clears
   always_ff @(posedge core_clk_in)
   begin
      if (lvd_reset_in & lvd_option_in)
         bor_flag <= 1'b1; // [R12] [R17] [R18]
      else if (halt_in)
         bor_flag <= bor_flag; // [R7]
      else if (wr_acc & ~pwdata[sim_pkg::SIM_BIT_BOR])
         bor_flag <= 1'b0; // [R12]
   end

   // Watchdog flag: low-voltage reset clears, watchdog sets
   always_ff @(posedge core_clk_in)
   begin
      if (lvd_reset_in & lvd_option_in)
         wdg_flag <= 1'b0; // [R16] [R17]
      else if (wdg_reset_in)
         wdg_flag <= 1'b1; // [R16] [R17]
      else if (srst_in)
         wdg_flag <= wdg_flag;
      else if (halt_in)
         wdg_flag <= wdg_flag; // [R7]
      else if (wr_acc & ~pwdata[sim_pkg::SIM_BIT_WDG])
         wdg_flag <= 1'b0; // [R16]
   end

   // ------------------------------------------------------------------
   // Safe-clock flag and interrupts
   // ------------------------------------------------------------------
   // Set while safe clock drives; read clears once recovered
   always_ff @(posedge core_clk_in)
   begin
      if (srst_in | ~guard_en)
         safe_flag <= 1'b0; // [R15]
      else if (guard_safe)
         safe_flag <= 1'b1; // [R4]
      else if (rd_acc)
         safe_flag <= 1'b0; // [R15]
   end

   // Supply warning pending: toggle sets, service entry clears
   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
         sw_pending <= 1'b0;
      else if (sw_toggle & sw_ie & lvd_option_in)
         sw_pending <= 1'b1; // [R10] [R20]
      else if (sw_irq_ack_in)
         sw_pending <= 1'b0; // [R10]
   end

   // Requests gated by CPU mask; wake only from wait
   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
      begin
         sw_irq_out <= 1'b0;
         cg_irq_out <= 1'b0;
         wake_out <= 1'b0;
         osc_filtered_out <= 1'b0;
         safe_select_out <= 1'b0;
      end
      else
      begin
         sw_irq_out <= sw_pending & ~cpu_int_mask_in; // [R5]
         cg_irq_out <= safe_flag & cg_ie & guard_en & ~cpu_int_mask_in; // [R5] [R14]
         wake_out <= wait_in & ~halt_in & (sw_pending | (safe_flag & cg_ie & guard_en)); // [R6]
         osc_filtered_out <= guard_filt; // [R1]
         safe_select_out <= guard_safe; // [R2] [R3]
      end
   end

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   a_apb_ready_one: assert property (@(posedge core_clk_in) disable iff (srst_in)
      psel && penable && !pready |=> pready) // [R21]
      else $error("pready not one cycle after access");
   a_read_live_status: assert property (@(posedge core_clk_in) disable iff (srst_in)
      psel && penable && !pready && !pwrite && hit |=> prdata[7:0] == $past(status))
      else $error("read data not live status"); // [R21]
   a_bit_three_zero: assert property (@(posedge core_clk_in) disable iff (srst_in)
      pready |-> prdata[3] == 1'b0 && prdata[7] == 1'b0) // [R9]
      else $error("reserved bit read nonzero");
   a_safe_flag_sets: assert property (@(posedge core_clk_in) disable iff (srst_in)
      guard_safe && guard_en |=> safe_flag) // [R4]
      else $error("safe flag not set");
   a_safe_forced_zero: assert property (@(posedge core_clk_in) disable iff (srst_in)
      !guard_en |-> status[sim_pkg::SIM_BIT_SAFE] == 1'b0) // [R15]
      else $error("safe flag not forced zero");
   a_irq_masked: assert property (@(posedge core_clk_in) disable iff (srst_in)
      $past(cpu_int_mask_in) |-> !sw_irq_out && !cg_irq_out) // [R5]
      else $error("interrupt raised while masked");
   a_no_halt_wake: assert property (@(posedge core_clk_in) disable iff (srst_in)
      $past(halt_in) |-> !wake_out) // [R6]
      else $error("wake during halt");
   a_toggle_pending: assert property (@(posedge core_clk_in) disable iff (srst_in)
      sw_toggle && sw_ie && lvd_option_in |=> sw_pending) // [R10]
      else $error("toggle lost");
   a_bor_sticky: assert property (@(posedge core_clk_in)
      bor_flag && !wr_acc |=> bor_flag) // [R18]
      else $error("brownout flag lost");
   a_wdg_lvd_clear: assert property (@(posedge core_clk_in)
      lvd_reset_in && lvd_option_in |=> !wdg_flag && bor_flag) // [R16]
      else $error("low-voltage reset encoding wrong");
   a_guard_frozen: assert property (@(posedge core_clk_in) disable iff (srst_in)
      halt_in && guard_en && $past(halt_in) |-> $stable(guard_safe)) // [R7]
      else $error("guard moved in halt");

   c_safe_switch: cover property (@(posedge core_clk_in) disable iff (srst_in)
      !guard_safe ##1 guard_safe);
   c_sw_irq: cover property (@(posedge core_clk_in) disable iff (srst_in) sw_irq_out);
   c_wait_wake: cover property (@(posedge core_clk_in) disable iff (srst_in) wake_out);
   c_safe_read_clear: cover property (@(posedge core_clk_in) disable iff (srst_in)
      safe_flag ##1 !safe_flag);
endmodule : sim_monitor

// File: core/sim_pkg.sv
/*
 Constants for the system integrity monitor: register map, bit positions,
 reset values, clock guard timing.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package sim_pkg;
   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam logic [11:0] SIM_ADDR_CTRL_STATUS = 12'h000;
   localparam logic [7:0] SIM_CTRL_STATUS_RESET = 8'h00;
   localparam logic [7:0] SIM_WRITE_MASK = 8'h51;
   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int SIM_BIT_SW_IE = 6;
   localparam int SIM_BIT_SW_FLAG = 5;
   localparam int SIM_BIT_BOR = 4;
   localparam int SIM_BIT_CG_IE = 2;
   localparam int SIM_BIT_SAFE = 1;
   localparam int SIM_BIT_WDG = 0;
   // ------------------------------------------------------------------
   // Clock guard timing
   // ------------------------------------------------------------------
   localparam int SIM_CLK_MHZ = 125;
   localparam int SIM_LOSS_TIME_NS = 64;
   localparam int SIM_LOSS_CYCLES = (SIM_LOSS_TIME_NS * SIM_CLK_MHZ) / 1000;
   localparam logic [3:0] SIM_LOSS_CNT_RESET = 4'h0;
   localparam int SIM_SYNC_STAGES = 2;
endpackage : sim_pkg

// File: core/sim_edge_sync.sv
/*
 Two-stage synchroniser with a toggle detector on the settled level.
 Assumes a single clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
module sim_edge_sync
(
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic srst_in,
   // Level in and out
   input wire logic level_in,
   output logic level_out,
   output logic toggle_out
);
   logic meta;
   logic settled;
   logic settled_q;

   // Two flops, first one read only by second
   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
      begin
         meta <= 1'b0;
         settled <= 1'b0;
      end
      else
      begin
         meta <= level_in;
         settled <= meta;
      end
   end

   // Delayed copy for change detection
   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
         settled_q <= 1'b0;
      else
         settled_q <= settled;
   end

   assign level_out = settled;
   assign toggle_out = settled ^ settled_q;
endmodule : sim_edge_sync

// File: core/sim_clock_guard.sv
/*
 Clock guard: glitch filter on the main oscillator edge stream and loss
 detector that selects the safe oscillator while edges are missing.
 Assumes the oscillator sample is synchronous to core_clk_in.
*/
`timescale 1ns/1ps
module sim_clock_guard
(
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic srst_in,
   // Control
   input wire logic enable_in,
   input wire logic freeze_in,
   input wire logic pll_on_in,
   // Oscillator sample
   input wire logic osc_sample_in,
   // Status
   output logic osc_filtered_out,
   output logic safe_select_out
);
   logic [2:0] hist;
   logic [3:0] loss_cnt;
   logic edge_seen;

   // Majority-of-three filter, bypassed when PLL is off
   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
      begin
         hist <= 3'h0;
         osc_filtered_out <= 1'b0;
      end
      else
      begin
         hist <= {hist[1:0], osc_sample_in};
         if (pll_on_in) // [R1]
            osc_filtered_out <= (hist[0] & hist[1]) | (hist[1] & hist[2]) | (hist[0] & hist[2]);
         else
            osc_filtered_out <= hist[0];
      end
   end

   assign edge_seen = hist[1] ^ hist[2];

   // Loss counter and safe selection; frozen in halt, reset restarts it
   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
      begin
         loss_cnt <= sim_pkg::SIM_LOSS_CNT_RESET; // [R8]
         safe_select_out <= 1'b0;
      end
      else if (!enable_in)
      begin
         loss_cnt <= sim_pkg::SIM_LOSS_CNT_RESET;
         safe_select_out <= 1'b0;
      end
      else if (!freeze_in) // [R7] [R8]
      begin
         if (edge_seen)
         begin
            loss_cnt <= sim_pkg::SIM_LOSS_CNT_RESET;
            safe_select_out <= 1'b0; // [R3]
         end
         else if (loss_cnt == 4'(sim_pkg::SIM_LOSS_CYCLES - 1))
            safe_select_out <= 1'b1; // [R2]
         else
            loss_cnt <= loss_cnt + 4'h1;
      end
   end
endmodule : sim_clock_guard

// File: bench/tb_system_integrity_monitor.sv
/*
 Self-checking bench for sim_monitor: APB register access, reset causes,
 supply warning interrupt, clock guard switching, wait and halt.
 Assumes the core files are compiled first and the bench drives every port.
*/
`timescale 1ns/1ps
module tb_system_integrity_monitor;
   // -----------------------------------------------------------------
   // Signals
   // -----------------------------------------------------------------
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, r, d;
   logic pready, pslverr, e;
   logic lvd_opt = 1'b1, grd_opt = 1'b1, lvd_rst = 1'b0, wdg_rst = 1'b0;
   logic sup_low = 1'b0, osc = 1'b0, osc_run = 1'b1, mask = 1'b0;
   logic halt = 1'b0, wt = 1'b0, ack = 1'b0, pll = 1'b1, glitch = 1'b0;
   logic osc_f, safe_sel, sw_irq, cg_irq, wake;
   logic [7:0] m = 8'h00;
   int fail_count = 0, checks_done = 0, cyc = 0, i, k;

   sim_monitor uut (.core_clk_in(clk), .srst_in(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .lvd_option_in(lvd_opt), .guard_option_in(grd_opt),
      .pll_on_in(pll), .lvd_reset_in(lvd_rst), .wdg_reset_in(wdg_rst),
      .supply_low_in(sup_low), .osc_sample_in(osc), .cpu_int_mask_in(mask),
      .halt_in(halt), .wait_in(wt), .sw_irq_ack_in(ack), .osc_filtered_out(osc_f),
      .safe_select_out(safe_sel), .sw_irq_out(sw_irq), .cg_irq_out(cg_irq),
      .wake_out(wake));

   // Clock, oscillator stream and hang guard
   initial
   begin
      forever #4 clk = ~clk;
   end
   always @(posedge clk)
   begin
      if (osc_run | glitch)
         osc <= ~osc;
      cyc <= cyc + 1;
      if (cyc > 20000)
      begin
         fail_count++;
         print_verdict();
      end
   end

   // -----------------------------------------------------------------
   // Tasks
   // -----------------------------------------------------------------
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : print_verdict

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dat);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= dat;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20)
      begin
         chk("pready", 1, 0);
         print_verdict();
      end
   endtask : apb

   // Read the register and compare with the model
   task automatic rd();
      apb(1'b0, sim_pkg::SIM_ADDR_CTRL_STATUS, 32'h0);
      chk("status", {24'h0, m}, r);
   endtask : rd

   // Write, model takes enables from data, write-zero clears flags 4 and 0
   task automatic wr(input logic [7:0] v);
      apb(1'b1, sim_pkg::SIM_ADDR_CTRL_STATUS, {24'h0, v});
      m = (m & 8'haa) | (v & 8'h44) | (m & v & 8'h11);
   endtask : wr

   // Six-cycle reset with an optional cause pulse in its first cycle
   task automatic rst(input logic lv, input logic wd);
      @(posedge clk);
      srst <= 1'b1;
      lvd_rst <= lv;
      wdg_rst <= wd;
      @(posedge clk);
      lvd_rst <= 1'b0;
      wdg_rst <= 1'b0;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      m = m & 8'h31;
      if (lv)
         m = (m & 8'hfe) | 8'h10;
      else if (wd)
         m[0] = 1'b1;
   endtask : rst

   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial
   begin
      void'($urandom(32'hf9bb));
      rst(1'b1, 1'b0);
      rd();
      wr(8'h00);
      rd();
      rst(1'b0, 1'b1);
      rd();
      rst(1'b1, 1'b0);
      rd();
      rst(1'b0, 1'b1);
      rd();
      wr(8'h00);
      rst(1'b0, 1'b0);
      rd();
      for (i = 0; i < 8; i++)
      begin
         d = $urandom & 32'h000000f7;
         wr(d[7:0]);
         rd();
      end
      apb(1'b1, 12'h004, 32'h000000ff);
      chk("slverr", 1, e);
      apb(1'b0, 12'h004, 32'h0);
      chk("unmapped", 0, r);
      rd();
      // Supply warning toggles, masking and detector option
      wr(8'h40);
      sup_low <= 1'b1;
      repeat (6) @(posedge clk);
      chk("sw_irq", 1, sw_irq);
      m[5] = 1'b1;
      rd();
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
      repeat (2) @(posedge clk);
      chk("sw_irq", 0, sw_irq);
      mask <= 1'b1;
      sup_low <= 1'b0;
      m[5] = 1'b0;
      repeat (6) @(posedge clk);
      chk("sw_irq", 0, sw_irq);
      rd();
      mask <= 1'b0;
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
      lvd_opt <= 1'b0;
      sup_low <= 1'b1;
      repeat (6) @(posedge clk);
      chk("sw_irq", 0, sw_irq);
      sup_low <= 1'b0;
      repeat (6) @(posedge clk);
      lvd_opt <= 1'b1;
      // Clock guard loss, recovery, wait and halt
      wr(8'h04);
      repeat (16) @(posedge clk);
      chk("safe", 0, safe_sel);
      osc_run <= 1'b0;
      repeat (16) @(posedge clk);
      chk("safe", 1, safe_sel);
      chk("cg_irq", 1, cg_irq);
      m[1] = 1'b1;
      rd();
      wt <= 1'b1;
      repeat (3) @(posedge clk);
      chk("wake", 1, wake);
      wt <= 1'b0;
      osc_run <= 1'b1;
      repeat (16) @(posedge clk);
      chk("safe", 0, safe_sel);
      rd();
      m[1] = 1'b0;
      rd();
      halt <= 1'b1;
      osc_run <= 1'b0;
      repeat (16) @(posedge clk);
      chk("safe", 0, safe_sel);
      halt <= 1'b0;
      repeat (16) @(posedge clk);
      chk("safe", 1, safe_sel);
      osc_run <= 1'b1;
      repeat (16) @(posedge clk);
      m[1] = 1'b1;
      rd();
      m[1] = 1'b0;
      grd_opt <= 1'b0;
      osc_run <= 1'b0;
      repeat (16) @(posedge clk);
      chk("cg_irq", 0, cg_irq);
      rd();
      // One-cycle oscillator spike: filtered with PLL on, passed with it off
      for (i = 0; i < 2; i++)
      begin
         pll <= (i == 0) ? 1'b1 : 1'b0;
         repeat (4) @(posedge clk);
         d = {31'h0, osc};
         glitch <= 1'b1;
         repeat (2) @(posedge clk);
         glitch <= 1'b0;
         k = 0;
         repeat (6)
         begin
            @(posedge clk);
            if (osc_f !== d[0])
               k++;
         end
         chk("filtered", i, k);
      end
      print_verdict();
   end
endmodule : tb_system_integrity_monitor
